// file: shared/spi_irq_pkg.sv
// Constants for the interrupt enable block of the memory-access slave
package spi_irq_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SYNC_STAGES = 2;

	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] HOST_EN_OFFSET = 8'h0c;
	localparam logic [7:0] PROC_EN_OFFSET = 8'h10;

	localparam logic [31:0] HOST_EN_RESET = 32'h0000_0000;
	localparam logic [31:0] PROC_EN_RESET = 32'h0000_0000;
	localparam logic [31:0] READ_NONE = 32'h0000_0000;

	// Bits 28..16: FIFO errors, size, destination busy, command, bus, limits, resets
	localparam logic [31:0] ERROR_EVENT_MASK = 32'h1fff_0000;
	localparam int OUT_BUF_FULL_BIT = 15;
	localparam int IN_BUF_FULL_BIT = 14;
	localparam int CLK_CNT_ERR_BIT = 13;
	// FIFO full/empty levels and upper-status attention
	localparam logic [31:0] LEVEL_MASK = 32'h0000_0f40;
	// Busy flags 5..3 and done flags 1..0
	localparam logic [31:0] BUSY_DONE_MASK = 32'h0000_003b;

	localparam logic [31:0] OUT_BUF_FULL_MASK = 32'h1 << OUT_BUF_FULL_BIT;
	localparam logic [31:0] IN_BUF_FULL_MASK = 32'h1 << IN_BUF_FULL_BIT;
	localparam logic [31:0] CLK_CNT_ERR_MASK = 32'h1 << CLK_CNT_ERR_BIT;

	localparam logic [31:0] HOST_EN_MASK = ERROR_EVENT_MASK | OUT_BUF_FULL_MASK
		| CLK_CNT_ERR_MASK | LEVEL_MASK | BUSY_DONE_MASK;
	localparam logic [31:0] PROC_EN_MASK = HOST_EN_MASK | IN_BUF_FULL_MASK;
endpackage

// file: shared/wr_xfer_if.sv
// Write transfer handed from the link bridge to the register logic
`timescale 1ns/1ps
`default_nettype none
interface wr_xfer_if;
	logic valid;
	logic [spi_irq_pkg::ADDR_W-1:0] addr;
	logic [spi_irq_pkg::DATA_W-1:0] data;
	modport src (output valid, output addr, output data);
	modport dst (input valid, input addr, input data);
endinterface
`default_nettype wire

// file: verilog/level_sync.sv
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Level in and synchronised level out
	input wire logic [WIDTH-1:0] level_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] stage1;

	// Only the second stage reads stage1
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1 <= '0;
			level_out <= '0;
		end
		else
		begin
			stage1 <= level_in;
			level_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// file: verilog/link_write_bridge.sv
// Toggle handshake moving one register write from the link clock to sys_clk
`timescale 1ns/1ps
`default_nettype none
module link_write_bridge (
	// Clocks and reset
	input wire logic link_clk,
	input wire logic sys_clk,
	input wire logic arst_n,
	// Link side write request
	input wire logic link_wr,
	input wire logic [spi_irq_pkg::ADDR_W-1:0] link_addr,
	input wire logic [spi_irq_pkg::DATA_W-1:0] link_wdata,
	output logic link_busy,
	// System side transfer
	wr_xfer_if.src xfer
);
	logic req_tgl;
	logic [spi_irq_pkg::ADDR_W-1:0] hold_addr;
	logic [spi_irq_pkg::DATA_W-1:0] hold_data;
	logic ack_sync;
	logic req_sync;
	logic req_seen;
	wire accept = link_wr && !link_busy;
	wire next_req_tgl = req_tgl ^ accept;
	wire req_edge = req_sync ^ req_seen;

	// Held data stays put until the ack returns, so it is safe to sample
	always_ff @(posedge link_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			req_tgl <= 1'b0;
			hold_addr <= '0;
			hold_data <= '0;
			link_busy <= 1'b0;
		end
		else
		begin
			req_tgl <= next_req_tgl;
			link_busy <= next_req_tgl ^ ack_sync;
			if (accept)
			begin
				hold_addr <= link_addr;
				hold_data <= link_wdata;
			end
		end
	end

	level_sync #(.WIDTH(1)) u_req_sync (
		.clk(sys_clk),
		.arst_n(arst_n),
		.level_in(req_tgl),
		.level_out(req_sync)
	);

	level_sync #(.WIDTH(1)) u_ack_sync (
		.clk(link_clk),
		.arst_n(arst_n),
		.level_in(req_seen),
		.level_out(ack_sync)
	);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			req_seen <= 1'b0;
			xfer.valid <= 1'b0;
			xfer.addr <= '0;
			xfer.data <= '0;
		end
		else
		begin
			req_seen <= req_sync;
			xfer.valid <= req_edge;
			xfer.addr <= hold_addr;
			xfer.data <= hold_data;
		end
	end
endmodule
`default_nettype wire

// file: verilog/spi_irq_enables.sv
// Interrupt enable registers and interrupt outputs of the memory-access slave
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Host enable at 0x0c gates master interrupt
// - Bits 28..19 enable FIFO, command, limit errors
// - Bits 18..15 reset-done, master reset, output-full
// - Bits 13, 11..8, 6, 5..3, 1..0 enabled
// - Host enable bits read/write, reset zero
// - Master reaches host enable only in advanced mode
// - Processor enable at 0x10 gates processor interrupt
// - Processor bits 28..16 match host layout
// - Processor bits 15, 14 enable buffer-full flags
// - Processor bit 13 is write-one-to-clear
// - Processor bits 11..8, 6 enabled; 12, 7 reserved
// - Processor enable resets zero; 31..29 reserved
// - Processor bits 5..3, 1..0 enabled; 2 reserved
// - Status flags come from status register at 0x08
module spi_irq_enables (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Link clock from the master side
	input wire logic link_clk,
	// Processor register port
	input wire logic proc_wr,
	input wire logic proc_rd,
	input wire logic [spi_irq_pkg::ADDR_W-1:0] proc_addr,
	input wire logic [spi_irq_pkg::DATA_W-1:0] proc_wdata,
	output logic [spi_irq_pkg::DATA_W-1:0] proc_rdata,
	// Master register writes, link clock domain
	input wire logic link_wr,
	input wire logic [spi_irq_pkg::ADDR_W-1:0] link_addr,
	input wire logic [spi_irq_pkg::DATA_W-1:0] link_wdata,
	output logic link_busy,
	// Mode and status from the rest of the peripheral
	input wire logic advanced_mode,
	input wire logic [spi_irq_pkg::DATA_W-1:0] status_flags,
	// Interrupt outputs
	output logic proc_irq,
	output logic host_irq
);
	logic [spi_irq_pkg::DATA_W-1:0] host_en;
	logic [spi_irq_pkg::DATA_W-1:0] proc_en;
	logic host_irq_level;

	wr_xfer_if xfer ();

	link_write_bridge u_bridge (
		.link_clk(link_clk),
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.link_wr(link_wr),
		.link_addr(link_addr),
		.link_wdata(link_wdata),
		.link_busy(link_busy),
		.xfer(xfer)
	);

	// Interrupt toward the master is a level; two flops suffice
	level_sync #(.WIDTH(1)) u_irq_sync (
		.clk(link_clk),
		.arst_n(arst_n),
		.level_in(host_irq_level),
		.level_out(host_irq)
	);

	// One compare shared by the processor and master decodes
	function automatic logic addr_hit(
		input logic [spi_irq_pkg::ADDR_W-1:0] addr,
		input logic [spi_irq_pkg::ADDR_W-1:0] offset
	);
		return addr == offset;
	endfunction

	// Shared by both outputs so the two gates cannot drift apart
	function automatic logic gate_any(
		input logic [spi_irq_pkg::DATA_W-1:0] flags,
		input logic [spi_irq_pkg::DATA_W-1:0] enables
	);
		return |(flags & enables);
	endfunction

	// Address decode
	wire proc_hit_host = addr_hit(proc_addr, spi_irq_pkg::HOST_EN_OFFSET);
	wire proc_hit_proc = addr_hit(proc_addr, spi_irq_pkg::PROC_EN_OFFSET);
	wire proc_hit_status = addr_hit(proc_addr, spi_irq_pkg::STATUS_OFFSET);
	wire proc_wr_host = proc_wr && proc_hit_host;
	wire proc_wr_proc = proc_wr && proc_hit_proc;
	// Master writes are dropped outside advanced mode
	wire link_wr_host = xfer.valid && advanced_mode
		&& addr_hit(xfer.addr, spi_irq_pkg::HOST_EN_OFFSET);

	// Processor wins a same-cycle collision; the master write is lost
	wire [spi_irq_pkg::DATA_W-1:0] host_wdata = proc_wr_host ? proc_wdata : xfer.data;
	wire host_load = proc_wr_host || link_wr_host;
	// Masking keeps reserved bits at zero
	wire [spi_irq_pkg::DATA_W-1:0] next_host_en =
		host_load ? (host_wdata & spi_irq_pkg::HOST_EN_MASK) : host_en;

	// Bit 13 only clears on a one; writes of zero leave it.
	wire [spi_irq_pkg::DATA_W-1:0] proc_plain_mask =
		spi_irq_pkg::PROC_EN_MASK & ~spi_irq_pkg::CLK_CNT_ERR_MASK;
	wire [spi_irq_pkg::DATA_W-1:0] proc_w1c_keep =
		proc_en & spi_irq_pkg::CLK_CNT_ERR_MASK & ~proc_wdata;
	// Layout covers errors, buffer flags, levels and busy/done
	wire [spi_irq_pkg::DATA_W-1:0] next_proc_en =
		proc_wr_proc ? ((proc_wdata & proc_plain_mask) | proc_w1c_keep) : proc_en;

	// Flags are taken from the status register as they stand
	wire next_host_irq = gate_any(status_flags, host_en);
	wire next_proc_irq = gate_any(status_flags, proc_en);

	wire [spi_irq_pkg::DATA_W-1:0] next_proc_rdata =
		!proc_rd ? proc_rdata :
		proc_hit_host ? host_en :
		proc_hit_proc ? proc_en :
		proc_hit_status ? status_flags :
		spi_irq_pkg::READ_NONE;

	// Both enables clear to zero on reset
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			host_en <= spi_irq_pkg::HOST_EN_RESET;
			proc_en <= spi_irq_pkg::PROC_EN_RESET;
		end
		else
		begin
			host_en <= next_host_en;
			proc_en <= next_proc_en;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			host_irq_level <= 1'b0;
			proc_irq <= 1'b0;
			proc_rdata <= spi_irq_pkg::READ_NONE;
		end
		else
		begin
			host_irq_level <= next_host_irq;
			proc_irq <= next_proc_irq;
			proc_rdata <= next_proc_rdata;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	host_resv_zero_a: assert property (
		(host_en & ~spi_irq_pkg::HOST_EN_MASK) == '0
	) else $error("host enable reserved bit set");

	proc_resv_zero_a: assert property (
		(proc_en & ~spi_irq_pkg::PROC_EN_MASK) == '0
	) else $error("processor enable reserved bit set");

	proc_irq_gate_a: assert property (
		##1 proc_irq == |($past(status_flags) & $past(proc_en))
	) else $error("processor interrupt does not follow flags and enables");

	host_irq_gate_a: assert property (
		##1 host_irq_level == |($past(status_flags) & $past(host_en))
	) else $error("master interrupt level does not follow flags and enables");

	host_write_a: assert property (
		proc_wr && proc_addr == spi_irq_pkg::HOST_EN_OFFSET
		|=> host_en == ($past(proc_wdata) & spi_irq_pkg::HOST_EN_MASK)
	) else $error("host enable write not stored");

	proc_write_a: assert property (
		proc_wr && proc_addr == spi_irq_pkg::PROC_EN_OFFSET
		|=> (proc_en & ~spi_irq_pkg::CLK_CNT_ERR_MASK)
			== ($past(proc_wdata) & spi_irq_pkg::PROC_EN_MASK
			& ~spi_irq_pkg::CLK_CNT_ERR_MASK)
	) else $error("processor enable write not stored");

	clk_err_w1c_a: assert property (
		!proc_en[spi_irq_pkg::CLK_CNT_ERR_BIT] |=> !proc_en[spi_irq_pkg::CLK_CNT_ERR_BIT]
	) else $error("write-one-to-clear enable bit was set");

	mode_gate_a: assert property (
		xfer.valid && !advanced_mode && !proc_wr |=> $stable(host_en)
	) else $error("master write taken outside advanced mode");

	link_write_a: assert property (
		xfer.valid && advanced_mode && xfer.addr == spi_irq_pkg::HOST_EN_OFFSET && !proc_wr
		|=> host_en == ($past(xfer.data) & spi_irq_pkg::HOST_EN_MASK)
	) else $error("master write in advanced mode not stored");

	read_back_a: assert property (
		proc_rd && proc_addr == spi_irq_pkg::HOST_EN_OFFSET |=> proc_rdata == $past(host_en)
	) else $error("host enable read back wrong");

	idle_write_a: assert property (
		!proc_wr && !xfer.valid |=> $stable(host_en) && $stable(proc_en)
	) else $error("enable changed without a write");

	// Reset and register groups
	reset_clear_a: assert property (
		disable iff (1'b0) !arst_n ##1 !arst_n
		|-> host_en == spi_irq_pkg::HOST_EN_RESET && proc_en == spi_irq_pkg::PROC_EN_RESET
			&& !proc_irq && !host_irq_level
	) else $error("enable or interrupt not cleared by reset");

	host_err_group_a: assert property (
		proc_wr_host
		|=> ((host_en ^ $past(proc_wdata)) & spi_irq_pkg::ERROR_EVENT_MASK) == '0
	) else $error("host error enables not stored");

	host_obf_a: assert property (
		proc_wr_host
		|=> host_en[spi_irq_pkg::OUT_BUF_FULL_BIT]
			== $past(proc_wdata[spi_irq_pkg::OUT_BUF_FULL_BIT])
			&& !host_en[spi_irq_pkg::IN_BUF_FULL_BIT]
	) else $error("host buffer enables wrong");

	host_level_group_a: assert property (
		proc_wr_host
		|=> ((host_en ^ $past(proc_wdata)) & (spi_irq_pkg::LEVEL_MASK
			| spi_irq_pkg::BUSY_DONE_MASK | spi_irq_pkg::CLK_CNT_ERR_MASK)) == '0
	) else $error("host level and busy enables not stored");

	proc_err_group_a: assert property (
		proc_wr_proc
		|=> ((proc_en ^ $past(proc_wdata)) & spi_irq_pkg::ERROR_EVENT_MASK) == '0
	) else $error("processor error enables not stored");

	proc_ibf_a: assert property (
		proc_wr_proc
		|=> proc_en[spi_irq_pkg::IN_BUF_FULL_BIT]
			== $past(proc_wdata[spi_irq_pkg::IN_BUF_FULL_BIT])
	) else $error("processor input buffer enable not stored");

	proc_level_group_a: assert property (
		proc_wr_proc
		|=> ((proc_en ^ $past(proc_wdata)) & spi_irq_pkg::LEVEL_MASK) == '0
	) else $error("processor level enables not stored");

	proc_busy_group_a: assert property (
		proc_wr_proc
		|=> ((proc_en ^ $past(proc_wdata)) & spi_irq_pkg::BUSY_DONE_MASK) == '0
	) else $error("processor busy and done enables not stored");

	// Writers of each register
	proc_only_writer_a: assert property (
		!proc_wr_proc |=> $stable(proc_en)
	) else $error("processor enable changed without a processor write");

	host_writers_a: assert property (
		!proc_wr_host && !link_wr_host |=> $stable(host_en)
	) else $error("host enable changed without a write");

	link_other_addr_a: assert property (
		xfer.valid && xfer.addr != spi_irq_pkg::HOST_EN_OFFSET && !proc_wr_host
		|=> $stable(host_en)
	) else $error("master write to another offset changed host enable");

	unmapped_write_a: assert property (
		proc_wr && !proc_hit_host && !proc_hit_proc && !xfer.valid
		|=> $stable(host_en) && $stable(proc_en)
	) else $error("unmapped write changed an enable");

	link_pulse_a: assert property (
		xfer.valid |=> !xfer.valid
	) else $error("master write handed over twice");

	// Read port
	proc_read_back_a: assert property (
		proc_rd && proc_addr == spi_irq_pkg::PROC_EN_OFFSET
		|=> proc_rdata == $past(proc_en)
	) else $error("processor enable read back wrong");

	status_read_a: assert property (
		proc_rd && proc_addr == spi_irq_pkg::STATUS_OFFSET
		|=> proc_rdata == $past(status_flags)
	) else $error("status read back wrong");

	unmapped_read_a: assert property (
		proc_rd && proc_addr != spi_irq_pkg::HOST_EN_OFFSET
		&& proc_addr != spi_irq_pkg::PROC_EN_OFFSET
		&& proc_addr != spi_irq_pkg::STATUS_OFFSET
		|=> proc_rdata == spi_irq_pkg::READ_NONE
	) else $error("unmapped read returned data");

	rdata_hold_a: assert property (
		!proc_rd |=> $stable(proc_rdata)
	) else $error("read data changed without a read");

	// Interrupt gating
	proc_irq_off_a: assert property (
		proc_en == '0 |=> !proc_irq
	) else $error("processor interrupt with all enables clear");

	host_irq_off_a: assert property (
		host_en == '0 |=> !host_irq_level
	) else $error("master interrupt with all enables clear");

	proc_irq_cov: cover property (!proc_irq ##1 proc_irq);
	host_irq_cov: cover property (!host_irq_level ##1 host_irq_level);
	link_write_cov: cover property (link_wr_host);
	clk_err_clear_cov: cover property (
		proc_wr && proc_addr == spi_irq_pkg::PROC_EN_OFFSET
		&& proc_wdata[spi_irq_pkg::CLK_CNT_ERR_BIT]
	);
	mode_drop_cov: cover property (xfer.valid && !advanced_mode);
endmodule
`default_nettype wire

// file: test/host_link_model.sv
// Link-side host model that writes the host enable register over the link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	// Link clock and handshake
	input wire logic link_clk,
	input wire logic link_busy,
	// Write request
	output logic link_wr,
	output logic [spi_irq_pkg::ADDR_W-1:0] link_addr,
	output logic [spi_irq_pkg::DATA_W-1:0] link_wdata
);
	initial
	begin
		link_wr = 1'b0;
		link_addr = 8'h00;
		link_wdata = 32'h0000_0000;
	end
	// Ok is low when the request or its acknowledge did not come in time
	task automatic write(input logic [7:0] a, input logic [31:0] d, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge link_clk);
		#1;
		link_wr = 1'b1;
		link_addr = a;
		link_wdata = d;
		for (n = 0; n < 20 && !ok; n++)
		begin
			ok = !link_busy;
			@(posedge link_clk);
		end
		#1;
		link_wr = 1'b0;
		// Released lines must not keep showing the last value
		link_addr = ~a;
		link_wdata = ~d;
		for (n = 0; n < 20 && link_busy; n++)
		begin
			@(posedge link_clk);
			#1;
		end
		ok = ok && !link_busy;
	endtask
endmodule
`default_nettype wire

// file: test/tb_spi_irq_enables.sv
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module tb_spi_irq_enables;
	logic sys_clk, arst_n, link_clk, proc_wr, proc_rd, advanced_mode;
	logic proc_irq, host_irq, link_busy, link_wr, rd_d1;
	// Expected {host, proc} pairs for single flags at bits 28, 14, 13 and 12
	localparam logic [7:0] IRQ_PAIRS = 8'h27;
	logic [7:0] proc_addr, link_addr;
	logic [31:0] proc_wdata, proc_rdata, link_wdata, status_flags, v, en;
	logic [31:0] exp_q[$];
	int fail_count, n_checks, seed;
	bit ok;
	spi_irq_enables dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .link_clk(link_clk),
		.proc_wr(proc_wr), .proc_rd(proc_rd), .proc_addr(proc_addr),
		.proc_wdata(proc_wdata), .proc_rdata(proc_rdata), .link_wr(link_wr),
		.link_addr(link_addr), .link_wdata(link_wdata), .link_busy(link_busy),
		.advanced_mode(advanced_mode), .status_flags(status_flags),
		.proc_irq(proc_irq), .host_irq(host_irq));
	host_link_model host_u (.link_clk(link_clk), .link_busy(link_busy), .link_wr(link_wr),
		.link_addr(link_addr), .link_wdata(link_wdata));
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Link clock runs at its own phase so the crossing is exercised
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Strobes last one edge; the idle edge after keeps two calls apart
	task automatic bus(input bit wr, input bit rd, input logic [7:0] a, input logic [31:0] d);
		proc_wr = wr;
		proc_rd = rd;
		proc_addr = a;
		proc_wdata = d;
		@(posedge sys_clk);
		#1;
		proc_wr = 1'b0;
		proc_rd = 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 32'h0000_0000);
	endtask
	task automatic lwrite(input logic [7:0] a, input logic [31:0] d);
		host_u.write(a, d, ok);
		if (!ok)
		begin
			fail_count++;
			$display("mismatch at %0t: master write handshake timed out", $time);
			complete_run();
		end
	endtask
	// Read data stands from the edge that takes the strobe, so it is taken one edge later
	always @(posedge sys_clk)
	begin
		if (rd_d1 && exp_q.size() > 0)
			check(proc_rdata, exp_q.pop_front());
		rd_d1 <= proc_rd;
	end
	initial
	begin
		seed = 32'hfabd4ed2;
		{arst_n, proc_wr, proc_rd, advanced_mode, rd_d1} = 5'h00;
		proc_addr = 8'h00;
		proc_wdata = 32'h0000_0000;
		status_flags = 32'h0000_0000;
		repeat (6) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		rd(spi_irq_pkg::HOST_EN_OFFSET, 32'h0000_0000);
		rd(spi_irq_pkg::PROC_EN_OFFSET, 32'h0000_0000);
		bus(1'b1, 1'b0, spi_irq_pkg::HOST_EN_OFFSET, 32'hffff_ffff);
		bus(1'b1, 1'b0, spi_irq_pkg::PROC_EN_OFFSET, 32'hffff_ffff);
		rd(spi_irq_pkg::HOST_EN_OFFSET, 32'h1fff_af7b);
		rd(spi_irq_pkg::PROC_EN_OFFSET, 32'h1fff_cf7b);
		rd(8'h04, 32'h0000_0000);
		for (int i = 0; i < 12; i++)
		begin
			en = $random(seed);
			v = $random(seed);
			if (i[0])
				v = v & ~en;
			bus(1'b1, 1'b0, spi_irq_pkg::PROC_EN_OFFSET, en);
			status_flags = v;
			rd(spi_irq_pkg::STATUS_OFFSET, v);
			check({31'h0, proc_irq}, {31'h0, |(v & en & 32'h1fff_cf7b)});
		end
		bus(1'b1, 1'b0, spi_irq_pkg::PROC_EN_OFFSET, 32'hffff_ffff);
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		// Bit 13 cannot be set on the processor side, so only the host sees it
		for (int i = 0; i < 4; i++)
		begin
			status_flags = 32'h1 << (i == 0 ? 28 : 15 - i);
			repeat (4) @(posedge link_clk);
			#1;
			check({30'h0, host_irq, proc_irq}, {30'h0, IRQ_PAIRS[2 * i +: 2]});
		end
		lwrite(spi_irq_pkg::HOST_EN_OFFSET, 32'h0000_0000);
		rd(spi_irq_pkg::HOST_EN_OFFSET, 32'h1fff_af7b);
		advanced_mode = 1'b1;
		v = $random(seed);
		lwrite(spi_irq_pkg::HOST_EN_OFFSET, v);
		@(posedge sys_clk);
		#1;
		rd(spi_irq_pkg::HOST_EN_OFFSET, v & 32'h1fff_af7b);
		status_flags = 32'h1fff_ffff;
		repeat (4) @(posedge link_clk);
		#1;
		check({31'h0, host_irq}, {31'h0, |(v & 32'h1fff_af7b)});
		check({31'h0, proc_irq}, 32'h0000_0001);
		// A second reset in mid-run must clear what the writes have set
		@(posedge sys_clk);
		#1;
		arst_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		check({30'h0, host_irq, proc_irq}, 32'h0000_0000);
		rd(spi_irq_pkg::HOST_EN_OFFSET, 32'h0000_0000);
		rd(spi_irq_pkg::PROC_EN_OFFSET, 32'h0000_0000);
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		repeat (3) @(posedge sys_clk);
		check(32'(exp_q.size()), 32'h0000_0000);
		complete_run();
	end
endmodule
`default_nettype wire
